/* File: inc/cm_pkg.sv */
// Constants shared by the cycle meter timer channel.
// Assumes a 16-bit register port with a 4-bit word address.
package cm_pkg;
	// Register word addresses
	localparam logic [3:0] ADDR_CONTROL  = 4'h0;
	localparam logic [3:0] ADDR_STATUS   = 4'h1;
	localparam logic [3:0] ADDR_IRQ_EN   = 4'h2;
	localparam logic [3:0] ADDR_COUNTER  = 4'h3;
	localparam logic [3:0] ADDR_CAPTURE  = 4'h4;
	localparam logic [3:0] ADDR_UPPER    = 4'h5;
	localparam logic [3:0] ADDR_LOWER    = 4'h6;
	// Control register bit positions
	localparam int CTL_MODE   = 0;
	localparam int CTL_START  = 1;
	localparam int CTL_EDGE   = 2;
	localparam int CTL_HALT   = 3;
	localparam int CTL_GATE   = 4;
	localparam int CTL_GPOL   = 5;
	localparam int CTL_EXTCLK = 6;
	localparam int CTL_EXTFAL = 7;
	localparam int CTL_WIDTH  = 8;
	// Flag and enable bit positions, in priority order
	localparam int FLG_CAPTURE = 0;
	localparam int FLG_MATCH   = 1;
	localparam int FLG_ABOVE   = 2;
	localparam int FLG_BELOW   = 3;
	localparam int FLG_WRAP    = 4;
	localparam int FLG_COUNT   = 5;
	// Reset values and counter wrap bounds
	localparam logic [7:0]  CONTROL_RST = 8'h00;
	localparam logic [4:0]  FLAGS_RST   = 5'h00;
	localparam logic [4:0]  IRQ_EN_RST  = 5'h00;
	localparam logic [15:0] WORD_RST    = 16'h0000;
	localparam logic [15:0] UPPER_RST   = 16'hFFFF;
	localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
	localparam logic [15:0] COUNT_ZERO  = 16'h0000;
	// Interrupt source codes
	localparam logic [2:0]  CODE_NONE   = 3'h0;
	// Cycle measurement sequence
	typedef enum logic [2:0] {
		ST_TIMER  = 3'b000,
		ST_FIRST  = 3'b001,
		ST_SECOND = 3'b010,
		ST_THIRD  = 3'b011,
		ST_HALT   = 3'b100
	} cm_state_t;
endpackage : cm_pkg

/* File: logic/cm_cycle_measure_timer.sv */
// 16-bit timer channel with timer mode and cycle measurement mode.
// Assumes all inputs are synchronous to sys_clk and one register access per cycle.
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module cm_cycle_measure_timer import cm_pkg::*; (
	input  wire logic        sys_clk,
	input  wire logic        reset,
	input  wire logic [3:0]  regAddr,
	input  wire logic [15:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [15:0] regRdata,
	input  wire logic        eventInput,
	input  wire logic        gateInput,
	input  wire logic        extCountClk,
	output logic             captureIrq,
	output logic             matchIrq,
	output logic             aboveLimitIrq,
	output logic             belowLimitIrq,
	output logic             wrapIrq,
	output logic      [2:0]  irqCode
);
	logic [7:0]      control_r;
	logic [4:0]      flags_r;
	logic [4:0]      flagSet;
	logic [4:0]      irqEnable_r;
	logic [4:0]      irq_r;
	logic [15:0]     measureCounter_r;
	logic [15:0]     measureCounter_nxt;
	logic [15:0]     captureReg_r;
	logic [15:0]     upperLimitReg_r;
	logic [15:0]     lowerLimitReg_r;
	logic [15:0]     regRdata_r;
	logic [15:0]     rdMux;
	logic [2:0]      irqCode_r;
	logic [2:0]      irqCode_nxt;
	logic            eventPrev_r;
	logic            extPrev_r;
	logic            edgePend_r;
	cm_state_t       state_r;
	cm_state_t       state_nxt;

	// Control fields
	wire modeSelect   = control_r[CTL_MODE];
	wire countStart   = control_r[CTL_START];
	wire edgeSelect   = control_r[CTL_EDGE];
	wire haltOnLimit  = control_r[CTL_HALT];
	wire gateSelect   = control_r[CTL_GATE];
	wire gatePolarity = control_r[CTL_GPOL];
	wire extClkSel    = control_r[CTL_EXTCLK];
	wire extClkFall   = control_r[CTL_EXTFAL];

	// Register port decode
	wire wrControl = regWr && (regAddr == ADDR_CONTROL);
	wire wrStatus  = regWr && (regAddr == ADDR_STATUS);
	wire wrIrqEn   = regWr && (regAddr == ADDR_IRQ_EN);
	wire wrCounter = regWr && (regAddr == ADDR_COUNTER);
	wire wrUpper   = regWr && (regAddr == ADDR_UPPER);
	wire wrLower   = regWr && (regAddr == ADDR_LOWER);
	wire rdCapture = regRd && (regAddr == ADDR_CAPTURE);

	// Count clock: every system clock, or a sampled edge of the external clock
	wire extRise   = extCountClk && !extPrev_r;
	wire extFallEv = !extCountClk && extPrev_r;
	wire countTick = extClkSel ? (extClkFall ? extFallEv : extRise) : 1'b1;

	// Mode and gating
	wire cycMode    = modeSelect;
	wire gateOk     = !gateSelect || (gateInput == gatePolarity);
	wire limitFlags = flags_r[FLG_ABOVE] || flags_r[FLG_BELOW];
	wire haltNow    = haltOnLimit && limitFlags;

	// Event edge, with one-clock deferral on access conflicts
	wire rawEdge   = edgeSelect ? (eventInput && !eventPrev_r) : (!eventInput && eventPrev_r);
	wire edgeAny   = rawEdge || edgePend_r;
	wire edgeBlock = cycMode ? (wrUpper || wrLower) : rdCapture;
	wire edgeNow   = edgeAny && !edgeBlock;
	wire edgeMeas  = edgeNow && gateOk;

	// Count enable per mode
	wire cycCountOk = (state_r != ST_TIMER) && (state_r != ST_HALT) && gateOk && !haltNow;
	wire countEn    = cycMode ? cycCountOk : countStart;
	wire incr       = countTick && countEn && !wrCounter;
	wire startClear = wrControl && !regWdata[CTL_START] && !regWdata[CTL_MODE] && !modeSelect;

	// Sequence steps in cycle measurement mode
	wire firstEdge  = cycMode && (state_r == ST_FIRST) && edgeMeas;
	wire secondEdge = cycMode && (state_r == ST_SECOND) && edgeMeas;
	wire thirdEdge  = cycMode && (state_r == ST_THIRD) && edgeMeas && !haltNow;
	wire restart    = cycMode && (state_r == ST_HALT) && !limitFlags;
	wire cycClear   = firstEdge || thirdEdge || restart;

	// Event sources for the flags
	wire wrapEv  = incr && (measureCounter_r == COUNT_MAX);
	wire matchEv = !cycMode && incr && (measureCounter_r == upperLimitReg_r) && !wrUpper;
	wire capEv   = !cycMode && edgeNow;
	wire aboveEv = secondEdge && (measureCounter_r > upperLimitReg_r);
	wire belowEv = secondEdge && (measureCounter_r < lowerLimitReg_r);

	assign flagSet[FLG_CAPTURE] = capEv;
	assign flagSet[FLG_MATCH]   = matchEv;
	assign flagSet[FLG_ABOVE]   = aboveEv;
	assign flagSet[FLG_BELOW]   = belowEv;
	assign flagSet[FLG_WRAP]    = wrapEv;

	// Counter next value; a software write wins over every other source
	always_comb begin
		measureCounter_nxt = measureCounter_r;
		if (wrCounter) begin
			measureCounter_nxt = regWdata;
		end else if (startClear || cycClear) begin
			measureCounter_nxt = COUNT_ZERO;
		end else if (incr) begin
			measureCounter_nxt = measureCounter_r + 16'h0001;
		end
	end

	// Measurement sequence
	always_comb begin
		state_nxt = state_r;
		if (!cycMode) begin
			state_nxt = ST_TIMER;
		end else begin
			case (state_r)
				ST_TIMER:  state_nxt = ST_FIRST;
				ST_FIRST:  if (firstEdge) state_nxt = ST_SECOND;
				ST_SECOND: if (secondEdge) state_nxt = ST_THIRD;
				ST_THIRD: begin
					if (haltNow) begin
						state_nxt = ST_HALT;
					end else if (thirdEdge) begin
						state_nxt = ST_SECOND;
					end
				end
				ST_HALT:   if (restart) state_nxt = ST_FIRST;
				default:   state_nxt = ST_TIMER;
			endcase
		end
	end

	// Highest pending enabled source: capture, match, above, below, wrap
	always_comb begin
		irqCode_nxt = CODE_NONE;
		for (int i = FLG_COUNT - 1; i >= 0; i--) begin
			if (flags_r[i] && irqEnable_r[i]) begin
				irqCode_nxt = 3'(i + 1);
			end
		end
	end

	// Control, enables, limits and sequence state
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			control_r       <= CONTROL_RST;
			irqEnable_r     <= IRQ_EN_RST;
			upperLimitReg_r <= UPPER_RST;
			lowerLimitReg_r <= WORD_RST;
			state_r         <= ST_TIMER;
		end else begin
			if (wrControl) control_r <= regWdata[CTL_WIDTH-1:0];
			if (wrIrqEn) irqEnable_r <= regWdata[FLG_COUNT-1:0];
			if (wrUpper) upperLimitReg_r <= regWdata;
			if (wrLower) lowerLimitReg_r <= regWdata;
			state_r <= state_nxt;
		end
	end

	// Counter, capture, edge history and read data
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			measureCounter_r <= WORD_RST;
			captureReg_r     <= WORD_RST;
			eventPrev_r      <= 1'b0;
			extPrev_r        <= 1'b0;
			edgePend_r       <= 1'b0;
			regRdata_r       <= WORD_RST;
			irqCode_r        <= CODE_NONE;
		end else begin
			measureCounter_r <= measureCounter_nxt;
			if (capEv || secondEdge) captureReg_r <= measureCounter_r;
			eventPrev_r <= eventInput;
			extPrev_r   <= extCountClk;
			edgePend_r  <= edgeAny && edgeBlock;
			regRdata_r  <= regRd ? rdMux : WORD_RST;
			irqCode_r   <= irqCode_nxt;
		end
	end

	// Read selection; unmapped addresses read zero
	always_comb begin
		case (regAddr)
			ADDR_CONTROL: rdMux = {8'h00, control_r};
			ADDR_STATUS:  rdMux = {11'h000, flags_r};
			ADDR_IRQ_EN:  rdMux = {11'h000, irqEnable_r};
			ADDR_COUNTER: rdMux = measureCounter_r;
			ADDR_CAPTURE: rdMux = captureReg_r;
			ADDR_UPPER:   rdMux = upperLimitReg_r;
			ADDR_LOWER:   rdMux = lowerLimitReg_r;
			default:      rdMux = WORD_RST;
		endcase
	end

	// Sticky flags and gated requests; a set beats a same-cycle clear
	genvar g;
	generate
		for (g = 0; g < FLG_COUNT; g++) begin : gFlag
			wire clr = wrStatus && !regWdata[g];
			always_ff @(posedge sys_clk) begin
				if (reset) begin
					flags_r[g] <= FLAGS_RST[g];
					irq_r[g]   <= 1'b0;
				end else begin
					flags_r[g] <= flagSet[g] || (flags_r[g] && !clr);
					irq_r[g]   <= flags_r[g] && irqEnable_r[g];
				end
			end
		end
	endgenerate

	assign regRdata      = regRdata_r;
	assign captureIrq    = irq_r[FLG_CAPTURE];
	assign matchIrq      = irq_r[FLG_MATCH];
	assign aboveLimitIrq = irq_r[FLG_ABOVE];
	assign belowLimitIrq = irq_r[FLG_BELOW];
	assign wrapIrq       = irq_r[FLG_WRAP];
	assign irqCode       = irqCode_r;

	// Checks on the channel's own behaviour
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	sequence sReadCollide;
		!cycMode && rawEdge && rdCapture;
	endsequence

	AST_RESET_TIMER: assert property ($fell(reset) |-> !modeSelect && state_r == ST_TIMER)
		else $error("channel not in timer mode after reset");
	AST_TIMER_HOLD: assert property (!cycMode && !countStart && !wrCounter && !wrControl
		|=> measureCounter_r == $past(measureCounter_r))
		else $error("counter moved while stopped");
	AST_WRAP: assert property (incr && measureCounter_r == COUNT_MAX
		|=> measureCounter_r == COUNT_ZERO && flags_r[FLG_WRAP])
		else $error("wrap did not clear counter and set flag");
	AST_CAPTURE: assert property (capEv |=> captureReg_r == $past(measureCounter_r)
		&& flags_r[FLG_CAPTURE])
		else $error("capture value or flag wrong");
	AST_MATCH: assert property (!cycMode && incr && measureCounter_r == upperLimitReg_r
		&& !wrUpper |=> flags_r[FLG_MATCH])
		else $error("match flag not set");
	AST_MATCH_SUPPRESS: assert property (wrUpper && !flags_r[FLG_MATCH] && !wrStatus
		|=> !flags_r[FLG_MATCH])
		else $error("match not suppressed by limit write");
	AST_FIRST_CLEAR: assert property (firstEdge && !wrCounter
		|=> measureCounter_r == COUNT_ZERO && state_r == ST_SECOND)
		else $error("first edge did not clear counter");
	AST_ABOVE: assert property (aboveEv |=> flags_r[FLG_ABOVE]
		&& captureReg_r > upperLimitReg_r)
		else $error("above limit not flagged");
	AST_BELOW: assert property (belowEv |=> flags_r[FLG_BELOW])
		else $error("below limit not flagged");
	AST_HALT: assert property (state_r == ST_HALT && !wrCounter
		|-> measureCounter_nxt == measureCounter_r || restart)
		else $error("counter ran while halted");
	AST_WRITE_WINS: assert property (wrCounter |=> measureCounter_r == $past(regWdata))
		else $error("counter write lost to count-up");
	AST_READ_DELAY: assert property (sReadCollide ##1 !rdCapture |=> flags_r[FLG_CAPTURE])
		else $error("deferred capture lost");
	AST_IRQ_GATE: assert property (##1 wrapIrq == $past(flags_r[FLG_WRAP] && irqEnable_r[FLG_WRAP]))
		else $error("wrap request not gated by enable");

	// Limit write colliding with an event edge in cycle mode
	sequence sLimitCollide;
		cycMode && rawEdge && (wrUpper || wrLower);
	endsequence

	// Timer mode forces the sequence back to its idle state
	AST_MODE_STATE: assert property (!cycMode |=> state_r == ST_TIMER)
		else $error("sequence not idle in timer mode");

	// Started timer counts every tick
	AST_TIMER_COUNT: assert property (!cycMode && countStart && countTick && !wrCounter && !wrControl
		|=> measureCounter_r == $past(measureCounter_r) + 16'h0001)
		else $error("started timer did not count");

	// Cycle mode counts without the start bit
	AST_CYC_COUNT: assert property (cycMode && state_r == ST_SECOND && gateOk && !haltNow
		&& countTick && !wrCounter |=> measureCounter_r == $past(measureCounter_r) + 16'h0001)
		else $error("cycle mode did not count");

	// Second edge copies the counter
	AST_CAPTURE_CYC: assert property (secondEdge |=> captureReg_r == $past(measureCounter_r))
		else $error("second edge capture wrong");

	// Third edge clears and starts the next round
	AST_THIRD_CLEAR: assert property (thirdEdge && !wrCounter
		|=> measureCounter_r == COUNT_ZERO && state_r == ST_SECOND)
		else $error("third edge did not restart round");

	// Without halt the sequence never stops
	AST_NO_HALT: assert property (cycMode && state_r == ST_THIRD && !haltOnLimit
		|=> state_r != ST_HALT)
		else $error("halted although halt disabled");

	// A limit flag with halt enabled stops measurement
	AST_HALT_ENTER: assert property (cycMode && state_r == ST_THIRD && haltNow
		|=> state_r == ST_HALT)
		else $error("limit flag did not halt");

	// Clearing the flags restarts from zero
	AST_RESTART: assert property (restart && !wrCounter
		|=> measureCounter_r == COUNT_ZERO && state_r == ST_FIRST)
		else $error("restart did not clear counter");

	// Closed gate freezes the counter
	AST_GATE_PAUSE: assert property (cycMode && gateSelect && gateInput != gatePolarity
		&& state_r != ST_HALT && !wrCounter && !wrControl |=> measureCounter_r == $past(measureCounter_r))
		else $error("counter moved with gate closed");

	// Low-active gate lets counting run while the input is low
	AST_GATE_LOW: assert property (cycMode && gateSelect && !gatePolarity && !gateInput
		&& state_r == ST_SECOND && !haltNow && countTick && !wrCounter
		|=> measureCounter_r == $past(measureCounter_r) + 16'h0001)
		else $error("counter stalled with low gate open");

	// Wrap before the first edge still flags a stopped input
	AST_WRAP_FIRST: assert property (cycMode && state_r == ST_FIRST && incr
		&& measureCounter_r == COUNT_MAX |=> flags_r[FLG_WRAP])
		else $error("wrap before first edge not flagged");

	// Capture outranks every other source
	AST_IRQ_CODE_CAPTURE: assert property (flags_r[FLG_CAPTURE] && irqEnable_r[FLG_CAPTURE]
		|=> irqCode_r == 3'h1)
		else $error("capture not highest priority");

	// Nothing enabled and pending gives no code
	AST_IRQ_NONE: assert property ((flags_r & irqEnable_r) == FLAGS_RST |=> irqCode_r == CODE_NONE)
		else $error("code without enabled request");

	// Edge during a limit write is held for one clock
	AST_EDGE_DEFER: assert property (sLimitCollide |=> edgePend_r)
		else $error("edge not deferred by limit write");

	// Enabled flags raise their own request lines
	AST_IRQ_CAPTURE: assert property (flags_r[FLG_CAPTURE] && irqEnable_r[FLG_CAPTURE] |=> captureIrq)
		else $error("capture request missing");

	// Match request follows its flag
	AST_IRQ_MATCH: assert property (flags_r[FLG_MATCH] && irqEnable_r[FLG_MATCH] |=> matchIrq)
		else $error("match request missing");

	// Above-limit request follows its flag
	AST_IRQ_ABOVE: assert property (flags_r[FLG_ABOVE] && irqEnable_r[FLG_ABOVE] |=> aboveLimitIrq)
		else $error("above request missing");

	// Below-limit request follows its flag
	AST_IRQ_BELOW: assert property (flags_r[FLG_BELOW] && irqEnable_r[FLG_BELOW] |=> belowLimitIrq)
		else $error("below request missing");
endmodule : cm_cycle_measure_timer

/* File: tb/cm_event_source.sv */
// Far-side model: measured event, gate level and external count clock.
// Assumes the bench calls its tasks; every change follows a rising edge.
`timescale 1ns/1ps
module cm_event_source (
	input  wire logic sys_clk,
	output logic      eventInput,
	output logic      gateInput,
	output logic      extCountClk
);
	// Idle levels; the count clock only moves inside a pulse burst
	initial begin
		eventInput = 1'b0;
		gateInput = 1'b0;
		extCountClk = 1'b0;
	end

	// Square wave of n periods, p clocks from edge to like edge
	task automatic wave(input int n, input int p);
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk);
			eventInput <= 1'b1;
			repeat (p / 2) @(posedge sys_clk);
			eventInput <= 1'b0;
			repeat (p - p / 2 - 1) @(posedge sys_clk);
		end
	endtask : wave

	// n count pulses, each level held two system clocks
	task automatic ext_pulses(input int n);
		repeat (2 * n) begin
			@(posedge sys_clk);
			extCountClk <= ~extCountClk;
			@(posedge sys_clk);
		end
	endtask : ext_pulses

	// Gate level change
	task automatic set_gate(input logic lvl);
		@(posedge sys_clk);
		gateInput <= lvl;
	endtask : set_gate
endmodule : cm_event_source

/* File: tb/test_cycle_measure_timer.sv */
// Bench for the cycle meter timer channel: bus tasks and scenarios.
// Assumes the event source model drives the event, gate and count pins.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_cycle_measure_timer import cm_pkg::*;;
	logic        sys_clk = 1'b0;
	logic        reset = 1'b1;
	logic [3:0]  regAddr = 4'h0;
	logic [15:0] regWdata = 16'h0000;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic [15:0] regRdata;
	wire logic   eventInput, gateInput, extCountClk;
	logic        captureIrq, matchIrq, aboveLimitIrq, belowLimitIrq, wrapIrq;
	logic [2:0]  irqCode;
	int          n_errors = 0;
	int          checked = 0;
	logic [15:0] v, w;

	// 200 MHz clock
	always #2.5 sys_clk = ~sys_clk;

	cm_cycle_measure_timer dut_u (.sys_clk(sys_clk), .reset(reset), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.eventInput(eventInput), .gateInput(gateInput), .extCountClk(extCountClk),
		.captureIrq(captureIrq), .matchIrq(matchIrq), .aboveLimitIrq(aboveLimitIrq),
		.belowLimitIrq(belowLimitIrq), .wrapIrq(wrapIrq), .irqCode(irqCode));
	cm_event_source src_u (.sys_clk(sys_clk), .eventInput(eventInput),
		.gateInput(gateInput), .extCountClk(extCountClk));

	// One-cycle write strobe
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge sys_clk);
		regWr <= 1'b0;
	endtask : wr
	// Read strobe; data taken in the cycle after it
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge sys_clk);
		regRd <= 1'b0;
		@(negedge sys_clk);
		d = regRdata;
	endtask : rd
	task automatic chk_rd(input logic [3:0] a, input logic [15:0] e);
		logic [15:0] d;
		rd(a, d);
		`CHK(d, e)
	endtask : chk_rd

	// Reset state and an unmapped address
	task automatic t_reset();
		chk_rd(ADDR_CONTROL, 16'h0000);
		chk_rd(ADDR_UPPER, 16'hFFFF);
		chk_rd(ADDR_COUNTER, 16'h0000);
		chk_rd(4'h9, 16'h0000);
	endtask : t_reset

	// External clock counts only pulses while started; with it deselected the counter steps every system clock
	task automatic t_count();
		wr(ADDR_CONTROL, 16'h0042);
		src_u.ext_pulses(5);
		repeat (4) @(posedge sys_clk);
		chk_rd(ADDR_COUNTER, 16'h0005);
		wr(ADDR_CONTROL, 16'h0002);
		wr(ADDR_COUNTER, 16'h1234);
		chk_rd(ADDR_COUNTER, 16'h1235);
	endtask : t_count

	// Capture on both edge choices, with and without the request enabled
	task automatic t_capture();
		wr(ADDR_CONTROL, 16'h0046);
		wr(ADDR_IRQ_EN, 16'h001F);
		wr(ADDR_COUNTER, 16'h0100);
		src_u.wave(1, 6);
		repeat (4) @(posedge sys_clk);
		chk_rd(ADDR_CAPTURE, 16'h0100);
		chk_rd(ADDR_STATUS, 16'h0001);
		`CHK({captureIrq, irqCode}, 4'h9)
		wr(ADDR_STATUS, 16'h001E);
		wr(ADDR_IRQ_EN, 16'h0000);
		wr(ADDR_CONTROL, 16'h0042);
		wr(ADDR_COUNTER, 16'h0200);
		src_u.wave(1, 6);
		repeat (4) @(posedge sys_clk);
		chk_rd(ADDR_CAPTURE, 16'h0200);
		chk_rd(ADDR_STATUS, 16'h0001);
		`CHK({captureIrq, irqCode}, 4'h0)
	endtask : t_capture

	// Match one count late, wrap, and request priority
	task automatic t_match_wrap();
		wr(ADDR_STATUS, 16'h0000);
		wr(ADDR_IRQ_EN, 16'h001E);
		wr(ADDR_UPPER, 16'h0003);
		wr(ADDR_COUNTER, 16'h0000);
		src_u.ext_pulses(3);
		repeat (4) @(posedge sys_clk);
		chk_rd(ADDR_STATUS, 16'h0000);
		src_u.ext_pulses(1);
		repeat (4) @(posedge sys_clk);
		chk_rd(ADDR_STATUS, 16'h0002);
		wr(ADDR_COUNTER, 16'hFFFE);
		src_u.ext_pulses(3);
		repeat (4) @(posedge sys_clk);
		chk_rd(ADDR_STATUS, 16'h0012);
		`CHK({matchIrq, wrapIrq, irqCode}, 5'h1A)
		wr(ADDR_STATUS, 16'h0010);
		repeat (3) @(posedge sys_clk);
		`CHK({matchIrq, wrapIrq, irqCode}, 5'h0D)
	endtask : t_match_wrap

	// Cycle measurement: limits, continuing rounds, halt, gate
	task automatic t_cycle();
		wr(ADDR_CONTROL, 16'h0000);
		wr(ADDR_STATUS, 16'h0000);
		wr(ADDR_UPPER, 16'h0020);
		wr(ADDR_LOWER, 16'h0008);
		wr(ADDR_CONTROL, 16'h0005);
		src_u.wave(3, 40);
		repeat (4) @(posedge sys_clk);
		rd(ADDR_CAPTURE, v);
		`CHK(v >= 16'd38 && v <= 16'd42, 1'b1)
		rd(ADDR_STATUS, v);
		`CHK({v[3:2], aboveLimitIrq}, 3'h3)
		src_u.wave(3, 4);
		repeat (4) @(posedge sys_clk);
		rd(ADDR_CAPTURE, v);
		`CHK(v >= 16'd3 && v <= 16'd5, 1'b1)
		rd(ADDR_STATUS, v);
		`CHK({v[3:2], belowLimitIrq}, 3'h7)
		wr(ADDR_STATUS, 16'h0000);
		wr(ADDR_CONTROL, 16'h000D);
		src_u.wave(3, 40);
		repeat (4) @(posedge sys_clk);
		rd(ADDR_COUNTER, v);
		repeat (10) @(posedge sys_clk);
		rd(ADDR_COUNTER, w);
		`CHK(w, v)
		wr(ADDR_STATUS, 16'h0000);
		wr(ADDR_CONTROL, 16'h0035);
		src_u.wave(3, 10);
		repeat (4) @(posedge sys_clk);
		chk_rd(ADDR_STATUS, 16'h0000);
		src_u.set_gate(1'b1);
		src_u.wave(3, 10);
		repeat (4) @(posedge sys_clk);
		rd(ADDR_CAPTURE, v);
		`CHK(v >= 16'd9 && v <= 16'd11, 1'b1)
	endtask : t_cycle

	// Counts and verdict, then end of run
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run

	// Main sequence after six cycles of reset
	initial begin
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		t_reset();
		t_count();
		t_capture();
		t_match_wrap();
		t_cycle();
		complete_run();
	end

	// Watchdog well past the expected run length
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_errors++;
		complete_run();
	end
endmodule : test_cycle_measure_timer
